/* common/tsf_cmp_if.sv */
`timescale 1ns/1ns
interface tsf_cmp_if;
	logic [4:0] hour;
	logic [5:0] min;
	logic [5:0] sec;
	logic [2:0] wday;
	logic [4:0] day;
	logic [4:0] t1_h;
	logic [5:0] t1_m;
	logic [5:0] t1_s;
	logic [4:0] t2_h;
	logic [5:0] t2_m;
	logic [5:0] t2_s;
	logic [4:0] a_day;
	logic [4:0] a_hour;
	logic [5:0] a_min;
	logic [5:0] a_sec;
	logic [6:0] week_en;
	logic [6:0] cond;
	modport src(output hour, min, sec, wday, day, t1_h, t1_m, t1_s, t2_h,
		t2_m, t2_s, a_day, a_hour, a_min, a_sec, week_en, input cond);
	modport cmp(input hour, min, sec, wday, day, t1_h, t1_m, t1_s, t2_h,
		t2_m, t2_s, a_day, a_hour, a_min, a_sec, week_en, output cond);
endinterface

/* common/tsf_pkg.sv */
package tsf_pkg;
	// clock and time base
	localparam int SYS_CLK_MHZ = 100;
	localparam int SEC_MS = 1000;
	localparam int SEC_CYCLES = SEC_MS * 1000 * SYS_CLK_MHZ;

	// sizes
	localparam int N_INT = 16;
	localparam int N_SHR = 5;
	localparam int N_IND = 8;
	localparam int N_FLAG = N_INT + N_SHR + N_IND;
	localparam int N_EXT = 16;
	localparam int N_COND = 7;
	localparam int SEL_W = 6;
	localparam int EQ_W = 20;
	localparam int POOL_W = 64;

	// register byte addresses
	localparam logic [7:0] A_TIMER1 = 8'h00;
	localparam logic [7:0] A_TIMER2 = 8'h04;
	localparam logic [7:0] A_ACTIVE = 8'h08;
	localparam logic [7:0] A_WEEK = 8'h0C;
	localparam logic [7:0] A_TIME = 8'h10;
	localparam logic [7:0] A_DATE = 8'h14;
	localparam logic [7:0] A_COND = 8'h18;
	localparam logic [7:0] A_FLAGS = 8'h1C;
	localparam logic [7:0] A_EQ = 8'h40;

	// field positions
	localparam int F_HOUR = 0;
	localparam int F_MIN = 8;
	localparam int F_SEC = 16;
	localparam int F_WDAY = 24;
	localparam int F_ADAY = 0;
	localparam int F_AHOUR = 8;
	localparam int F_AMIN = 16;
	localparam int F_ASEC = 24;
	localparam int F_DAY = 0;
	localparam int F_MLEN = 8;
	localparam int EQ_A = 0;
	localparam int EQ_B = 6;
	localparam int EQ_C = 12;
	localparam int EQ_OP1 = 18;
	localparam int EQ_OP2 = 19;

	// condition order on the condition output
	localparam int C_TMR1 = 0;
	localparam int C_TMR2 = 1;
	localparam int C_WEEK = 2;
	localparam int C_DAY = 3;
	localparam int C_HOUR = 4;
	localparam int C_MIN = 5;
	localparam int C_SEC = 6;

	// ranges and reset values
	localparam logic [5:0] MAX_HOUR = 6'h17;
	localparam logic [5:0] MAX_MS = 6'h3B;
	localparam logic [5:0] MIN_DAY = 6'h01;
	localparam logic [5:0] MAX_DAY = 6'h1F;
	localparam logic [5:0] MIN_MLEN = 6'h1C;
	localparam logic [2:0] MAX_WDAY = 3'h6;
	localparam logic [4:0] T1_HOUR_RST = 5'h08;
	localparam logic [4:0] T2_HOUR_RST = 5'h11;
	localparam logic [4:0] ADAY_RST = 5'h01;
	localparam logic [4:0] AHOUR_RST = 5'h0C;
	localparam logic [6:0] WEEK_RST = 7'h1F;
	localparam logic [4:0] MLEN_RST = 5'h1F;
	localparam logic [EQ_W-1:0] EQ_RST = 20'h01040;

	function automatic logic [16:0] tsf_sod(input logic [4:0] h,
		input logic [5:0] m, input logic [5:0] s);
		return 17'(h) * 17'h00E10 + 17'(m) * 17'h0003C + 17'(s);
	endfunction
endpackage

/* core/tsf_flag_logic.sv */
`timescale 1ns/1ns
// Summary of operation
// - timers assert at set time until midnight
// - timer hours 0-23, reset 8 and 17
// - timer minutes, seconds 0-59, reset zero
// - day output matches day of month, default 1
// - hour output every day, default 12
// - minute output every hour, default 0
// - second output every minute, default 0
// - weekly output all day on selected weekdays
// - seven conditions: timers, weekday, day, hour, minute, second
// - sixteen internal flags from equations
// - five shared flags sent to peers
// - eight indicator flags drive LEDs or internal
// - flag equations reset to false expression
// - weekday enables default Monday to Friday
module tsf_flag_logic
	import tsf_pkg::*;
#(
	parameter int CYC_PER_SEC = SEC_CYCLES,
	parameter bit HAS_LEDS = 1'b1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// other equation inputs
	input wire logic [N_EXT-1:0] ext_cond_in,
	// conditions and flags
	output logic [N_COND-1:0] cond_out,
	output logic [N_INT-1:0] int_flag_out,
	output logic [N_SHR-1:0] shared_peer_flag_out,
	output logic [N_IND-1:0] indicator_flag_out,
	output logic [N_IND-1:0] led_drive_out
);
	tsf_cmp_if cmp ();

	logic [31:0] div_ff;
	logic tick_ff, eval_ff;
	logic [5:0] sec_ff, min_ff;
	logic [4:0] hour_ff, day_ff, mlen_ff;
	logic [2:0] wday_ff;
	logic [4:0] t1_h_ff, t2_h_ff, ad_ff, ah_ff;
	logic [5:0] t1_m_ff, t1_s_ff, t2_m_ff, t2_s_ff, am_ff, as_ff;
	logic [6:0] week_ff;
	logic [N_COND-1:0] cond_ff;
	logic [N_FLAG-1:0] flag_ff, nxt_flag;
	logic [EQ_W-1:0] eq_ff [N_FLAG];
	logic [POOL_W-1:0] pool;
	logic [31:0] rd_val;
	logic map_ok, is_eq, setup, wr_en;
	logic [7:0] eq_off;
	logic [4:0] eq_idx;

	function automatic logic [5:0] tsf_pick(input logic [5:0] old_v,
		input logic [5:0] new_v, input logic [5:0] lo, input logic [5:0] hi);
		return (new_v >= lo && new_v <= hi) ? new_v : old_v;
	endfunction

	function automatic logic tsf_eq(input logic [EQ_W-1:0] eq,
		input logic [POOL_W-1:0] p);
		logic x;
		x = eq[EQ_OP1] ? (p[eq[EQ_A +: SEL_W]] | p[eq[EQ_B +: SEL_W]])
			: (p[eq[EQ_A +: SEL_W]] & p[eq[EQ_B +: SEL_W]]);
		return eq[EQ_OP2] ? (x | p[eq[EQ_C +: SEL_W]])
			: (x & p[eq[EQ_C +: SEL_W]]);
	endfunction

	// apb decode
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite & ~pslverr;
	assign eq_off = paddr - A_EQ;
	assign eq_idx = eq_off[6:2];
	assign is_eq = paddr >= A_EQ && eq_off[7:2] < 6'(N_FLAG);

	always_comb begin
		rd_val = 32'h0000_0000;
		map_ok = paddr[1:0] == 2'h0;
		if (paddr == A_TIMER1) begin
			rd_val = {10'h000, t1_s_ff, 2'h0, t1_m_ff, 3'h0, t1_h_ff};
		end else if (paddr == A_TIMER2) begin
			rd_val = {10'h000, t2_s_ff, 2'h0, t2_m_ff, 3'h0, t2_h_ff};
		end else if (paddr == A_ACTIVE) begin
			rd_val = {2'h0, as_ff, 2'h0, am_ff, 3'h0, ah_ff, 3'h0, ad_ff};
		end else if (paddr == A_WEEK) begin
			rd_val = {25'h0000000, week_ff};
		end else if (paddr == A_TIME) begin
			rd_val = {5'h00, wday_ff, 2'h0, sec_ff, 2'h0, min_ff, 3'h0,
				hour_ff};
		end else if (paddr == A_DATE) begin
			rd_val = {19'h00000, mlen_ff, 3'h0, day_ff};
		end else if (paddr == A_COND) begin
			rd_val = {25'h0000000, cond_ff};
		end else if (paddr == A_FLAGS) begin
			rd_val = {flag_ff[N_FLAG-1 -: N_IND], 3'h0,
				flag_ff[N_INT +: N_SHR], flag_ff[N_INT-1:0]};
		end else if (is_eq && map_ok) begin
			rd_val = {12'h000, eq_ff[eq_idx]};
		end else begin
			map_ok = 1'b0;
		end
	end

	// zero wait states: pready rises in the first access cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_val;
				pslverr <= ~map_ok;
			end
		end
	end

	// one-second time base; a time write restarts the second
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			div_ff <= 32'h0000_0000;
			tick_ff <= 1'b0;
			eval_ff <= 1'b0;
		end else begin
			eval_ff <= tick_ff;
			if (wr_en && paddr == A_TIME) begin
				div_ff <= 32'h0000_0000;
				tick_ff <= 1'b0;
			end else if (div_ff == 32'(CYC_PER_SEC - 1)) begin
				div_ff <= 32'h0000_0000;
				tick_ff <= 1'b1;
			end else begin
				div_ff <= div_ff + 32'h0000_0001;
				tick_ff <= 1'b0;
			end
		end
	end

	// calendar; software write wins over the tick
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			sec_ff <= 6'h00;
			min_ff <= 6'h00;
			hour_ff <= 5'h00;
			wday_ff <= 3'h0;
			day_ff <= 5'h01;
			mlen_ff <= MLEN_RST;
		end else if (wr_en && paddr == A_TIME) begin
			hour_ff <= 5'(tsf_pick({1'b0, hour_ff},
				pwdata[F_HOUR +: 6], 6'h00, MAX_HOUR));
			min_ff <= tsf_pick(min_ff, pwdata[F_MIN +: 6], 6'h00, MAX_MS);
			sec_ff <= tsf_pick(sec_ff, pwdata[F_SEC +: 6], 6'h00, MAX_MS);
			if (pwdata[F_WDAY +: 3] <= MAX_WDAY) begin
				wday_ff <= pwdata[F_WDAY +: 3];
			end
		end else if (wr_en && paddr == A_DATE) begin
			day_ff <= 5'(tsf_pick({1'b0, day_ff}, pwdata[F_DAY +: 6],
				MIN_DAY, {1'b0, mlen_ff}));
			mlen_ff <= 5'(tsf_pick({1'b0, mlen_ff},
				pwdata[F_MLEN +: 6], MIN_MLEN, MAX_DAY));
		end else if (tick_ff) begin
			if (sec_ff != MAX_MS) begin
				sec_ff <= sec_ff + 6'h01;
			end else begin
				sec_ff <= 6'h00;
				if (min_ff != MAX_MS) begin
					min_ff <= min_ff + 6'h01;
				end else begin
					min_ff <= 6'h00;
					if (hour_ff != MAX_HOUR[4:0]) begin
						hour_ff <= hour_ff + 5'h01;
					end else begin
						hour_ff <= 5'h00;
						wday_ff <= (wday_ff == MAX_WDAY) ? 3'h0
							: wday_ff + 3'h1;
						day_ff <= (day_ff >= mlen_ff) ? 5'h01
							: day_ff + 5'h01;
					end
				end
			end
		end
	end

	// setpoints; an out-of-range field keeps its old value
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			t1_h_ff <= T1_HOUR_RST;
			t2_h_ff <= T2_HOUR_RST;
			t1_m_ff <= 6'h00;
			t1_s_ff <= 6'h00;
			t2_m_ff <= 6'h00;
			t2_s_ff <= 6'h00;
			ad_ff <= ADAY_RST;
			ah_ff <= AHOUR_RST;
			am_ff <= 6'h00;
			as_ff <= 6'h00;
			week_ff <= WEEK_RST;
		end else if (wr_en) begin
			if (paddr == A_TIMER1) begin
				t1_h_ff <= 5'(tsf_pick({1'b0, t1_h_ff},
					pwdata[F_HOUR +: 6], 6'h00, MAX_HOUR));
				t1_m_ff <= tsf_pick(t1_m_ff, pwdata[F_MIN +: 6], 6'h00,
					MAX_MS);
				t1_s_ff <= tsf_pick(t1_s_ff, pwdata[F_SEC +: 6], 6'h00,
					MAX_MS);
			end else if (paddr == A_TIMER2) begin
				t2_h_ff <= 5'(tsf_pick({1'b0, t2_h_ff},
					pwdata[F_HOUR +: 6], 6'h00, MAX_HOUR));
				t2_m_ff <= tsf_pick(t2_m_ff, pwdata[F_MIN +: 6], 6'h00,
					MAX_MS);
				t2_s_ff <= tsf_pick(t2_s_ff, pwdata[F_SEC +: 6], 6'h00,
					MAX_MS);
			end else if (paddr == A_ACTIVE) begin
				ad_ff <= 5'(tsf_pick({1'b0, ad_ff},
					pwdata[F_ADAY +: 6], MIN_DAY, MAX_DAY));
				ah_ff <= 5'(tsf_pick({1'b0, ah_ff},
					pwdata[F_AHOUR +: 6], 6'h00, MAX_HOUR));
				am_ff <= tsf_pick(am_ff, pwdata[F_AMIN +: 6], 6'h00,
					MAX_MS);
				as_ff <= tsf_pick(as_ff, pwdata[F_ASEC +: 6], 6'h00,
					MAX_MS);
			end else if (paddr == A_WEEK) begin
				week_ff <= pwdata[6:0];
			end
		end
	end

	// comparator feed
	assign cmp.hour = hour_ff;
	assign cmp.min = min_ff;
	assign cmp.sec = sec_ff;
	assign cmp.wday = wday_ff;
	assign cmp.day = day_ff;
	assign cmp.t1_h = t1_h_ff;
	assign cmp.t1_m = t1_m_ff;
	assign cmp.t1_s = t1_s_ff;
	assign cmp.t2_h = t2_h_ff;
	assign cmp.t2_m = t2_m_ff;
	assign cmp.t2_s = t2_s_ff;
	assign cmp.a_day = ad_ff;
	assign cmp.a_hour = ah_ff;
	assign cmp.a_min = am_ff;
	assign cmp.a_sec = as_ff;
	assign cmp.week_en = week_ff;

	tsf_setpoint_cmp u_cmp (
		.c(cmp)
	);

	// sampled the cycle after the tick, so the new time is seen
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cond_ff <= 7'h00;
		end else if (eval_ff) begin
			cond_ff <= cmp.cond;
		end
	end

	// equation storage
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < N_FLAG; i++) begin
				eq_ff[i] <= EQ_RST;
			end
		end else if (wr_en && is_eq) begin
			eq_ff[eq_idx] <= pwdata[EQ_W-1:0];
		end
	end

	// source pool: 0 false, 1 true, conditions, flags, external
	assign pool = {10'h000, ext_cond_in, flag_ff, cond_ff, 1'b1, 1'b0};

	// flags feed back through a register, so loops cannot race
	always_comb begin
		for (int i = 0; i < N_FLAG; i++) begin
			nxt_flag[i] = tsf_eq(eq_ff[i], pool);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			flag_ff <= 29'h0000_0000;
			led_drive_out <= 8'h00;
		end else begin
			flag_ff <= nxt_flag;
			// display variant: indicator flags stay internal
			led_drive_out <= HAS_LEDS ? flag_ff[N_FLAG-1 -: N_IND]
				: 8'h00;
		end
	end

	assign cond_out = cond_ff;
	assign int_flag_out = flag_ff[N_INT-1:0];
	assign shared_peer_flag_out = flag_ff[N_INT +: N_SHR];
	assign indicator_flag_out = flag_ff[N_FLAG-1 -: N_IND];

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence s_eval;
		eval_ff;
	endsequence

	sequence s_time_ge_t1;
		tsf_sod(hour_ff, min_ff, sec_ff) >= tsf_sod(t1_h_ff, t1_m_ff, t1_s_ff);
	endsequence

	a_timer_one_on: assert property (s_eval ##0 s_time_ge_t1 |=>
		cond_out[C_TMR1]) else $error("timer one not asserted");
	a_timer_two_off: assert property (s_eval ##0
		(tsf_sod(hour_ff, min_ff, sec_ff) < tsf_sod(t2_h_ff, t2_m_ff, t2_s_ff))
		|=> !cond_out[C_TMR2]) else $error("timer two early");
	a_hour_reset: assert property ($rose(rst_b) |->
		t1_h_ff == 5'h08 && t2_h_ff == 5'h11 && ah_ff == 5'h0C)
		else $error("hour reset values wrong");
	a_setpt_range: assert property (t1_h_ff <= 5'h17 && t2_m_ff <= 6'h3B
		&& t1_s_ff <= 6'h3B && t1_m_ff <= 6'h3B && t2_s_ff <= 6'h3B)
		else $error("setpoint out of range");
	a_day_match: assert property (s_eval |=>
		cond_out[C_DAY] == ($past(day_ff) == $past(ad_ff)))
		else $error("day output wrong");
	a_hour_match: assert property (s_eval |=>
		cond_out[C_HOUR] == ($past(hour_ff) == $past(ah_ff)))
		else $error("hour output wrong");
	a_min_match: assert property (s_eval |=>
		cond_out[C_MIN] == ($past(min_ff) == $past(am_ff)))
		else $error("minute output wrong");
	a_sec_match: assert property (s_eval |=>
		cond_out[C_SEC] == ($past(sec_ff) == $past(as_ff)))
		else $error("second output wrong");
	a_week_match: assert property (s_eval |=>
		cond_out[C_WEEK] == $past(week_ff[wday_ff]))
		else $error("weekly output wrong");
	a_flag_default: assert property ($rose(rst_b) |->
		int_flag_out == 16'h0000 ##1 int_flag_out == 16'h0000 &&
		shared_peer_flag_out == 5'h00)
		else $error("flags not cleared after reset");
	a_week_reset: assert property ($rose(rst_b) |-> week_ff == 7'h1F)
		else $error("weekday enables reset wrong");
	a_tick_gap: assert property (tick_ff |=> !tick_ff)
		else $error("tick longer than one cycle");
	a_led_follow: assert property (##1 led_drive_out ==
		(HAS_LEDS ? $past(indicator_flag_out) : 8'h00))
		else $error("indicator drive mismatch");
endmodule // tsf_flag_logic

/* core/tsf_setpoint_cmp.sv */
`timescale 1ns/1ns
module tsf_setpoint_cmp
	import tsf_pkg::*;
(
	tsf_cmp_if.cmp c
);
	logic [16:0] now_sod;

	always_comb begin
		now_sod = tsf_sod(c.hour, c.min, c.sec);
		// held from set time until midnight wraps time of day
		c.cond[C_TMR1] = now_sod >= tsf_sod(c.t1_h, c.t1_m, c.t1_s);
		c.cond[C_TMR2] = now_sod >= tsf_sod(c.t2_h, c.t2_m, c.t2_s);
		c.cond[C_WEEK] = c.week_en[c.wday];
		c.cond[C_DAY] = c.day == c.a_day;
		c.cond[C_HOUR] = c.hour == c.a_hour;
		c.cond[C_MIN] = c.min == c.a_min;
		c.cond[C_SEC] = c.sec == c.a_sec;
	end
endmodule // tsf_setpoint_cmp

/* dv/tsf_flag_logic_bench.sv */
`timescale 1ns/1ns
module tsf_flag_logic_bench
	import tsf_pkg::*;
;
	logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [N_EXT-1:0] ext_cond_in;
	logic [N_COND-1:0] cond_out;
	logic [N_INT-1:0] int_flag_out;
	logic [N_SHR-1:0] shared_peer_flag_out, peer_rx;
	logic [N_IND-1:0] indicator_flag_out, led_drive_out;
	int num_errors = 0;
	int comparisons = 0;
	int seed = 86142;
	logic [32:0] exp_q[$];

	// short second keeps the calendar walk fast
	tsf_flag_logic #(.CYC_PER_SEC(10), .HAS_LEDS(1'b1)) dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_cond_in(ext_cond_in),
		.cond_out(cond_out), .int_flag_out(int_flag_out),
		.shared_peer_flag_out(shared_peer_flag_out),
		.indicator_flag_out(indicator_flag_out),
		.led_drive_out(led_drive_out)
	);

	tsf_peer_model peer (
		.sys_clk(sys_clk), .rst_b(rst_b),
		.flags_in(shared_peer_flag_out), .rx_ff(peer_rx)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task finish_test;
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// one apb transfer; reads note {pslverr, prdata} as expected
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) exp_q.push_back(e);
		@(posedge sys_clk);
		penable <= 1'b1;
		// wait as long as the slave needs; the watchdog bounds it
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [32:0] e);
		apb(1'b0, a, 32'h0, e);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask

	// set the second before, let one tick pass, read the conditions
	task tcase(input logic [31:0] tm, input logic [6:0] c);
		wr(A_TIME, tm);
		repeat (14) @(posedge sys_clk);
		rd(A_COND, {26'h0, c});
		check(33'(cond_out), 33'(c));
	endtask

	// read monitor takes the oldest note per completed read
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
			if (exp_q.size() == 0) begin
				num_errors++;
			end else begin
				check({pslverr, prdata}, exp_q.pop_front());
			end
		end
	end

	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ext_cond_in = '0;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(A_TIMER1, 33'h000000008);
		rd(A_TIMER2, 33'h000000011);
		rd(A_ACTIVE, 33'h000000C01);
		rd(A_WEEK, 33'h00000001F);
		rd(A_FLAGS, 33'h000000000);
		rd(A_EQ, 33'h000001040);
		rd(8'h90, 33'h000001040);
		rd(8'h20, 33'h100000000);
		rd(8'h01, 33'h100000000);
		$display("test reset done");
		// hour 24 and minute 60 refused, second applied
		wr(A_TIMER1, 32'h00053C18);
		rd(A_TIMER1, 33'h000050008);
		wr(A_TIMER1, 32'h003B3B17);
		rd(A_TIMER1, 33'h0003B3B17);
		wr(A_ACTIVE, 32'h1E140A00);
		rd(A_ACTIVE, 33'h01E140A01);
		$display("test ranges done");
		wr(A_TIMER1, 32'h001E140A);
		wr(A_TIMER2, 32'h003B3B17);
		wr(A_ACTIVE, 32'h1E140A05);
		wr(A_WEEK, 32'h00000041);
		wr(A_DATE, 32'h00001F05);
		tcase(32'h001D140A, 7'h7D);
		tcase(32'h011C140A, 7'h38);
		tcase(32'h063A3B17, 7'h0F);
		tcase(32'h063B3B17, 7'h04);
		$display("test calendar done");
		wr(A_EQ, 32'h00001041);
		wr(8'h80, 32'h000C0980);
		wr(8'h94, 32'h00001049);
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk);
			ext_cond_in <= N_EXT'($random(seed));
			repeat (4) @(posedge sys_clk);
			check(33'(peer_rx), 33'(ext_cond_in[0]));
			check(33'(int_flag_out), 33'h1);
			check(33'(led_drive_out), 33'h1);
			check(33'(indicator_flag_out), 33'h1);
			rd(A_FLAGS, {9'h001, 7'h0, ext_cond_in[0], 16'h0001});
		end
		$display("test flags done");
		// mid-run reset must drop every configured flag and the timer one setpoint
		rst_b <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(A_FLAGS, 33'h000000000);
		rd(A_EQ, 33'h000001040);
		rd(A_TIMER1, 33'h000000008);
		check(33'(led_drive_out), 33'h0);
		$display("test mid-run reset done");
		@(posedge sys_clk);
		check(33'(exp_q.size()), 33'h0);
		finish_test();
	end

	initial begin
		#200000;
		num_errors++;
		finish_test();
	end
endmodule // tsf_flag_logic_bench

/* dv/tsf_peer_model.sv */
`timescale 1ns/1ns
module tsf_peer_model
	import tsf_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// shared flags as seen on the bus
	input wire logic [N_SHR-1:0] flags_in,
	output logic [N_SHR-1:0] rx_ff
);
	// a peer latches the flags one cycle late, like a frame receiver
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rx_ff <= '0;
		end else begin
			rx_ff <= flags_in;
		end
	end
endmodule // tsf_peer_model
